// ==== sii_pkg.sv ====
// Package of constants for the serial I/O interrupt interface
package sii_pkg;
    localparam int SII_NUM_INT = 15;
    localparam int SII_NUM_INT_ONLY = 6;
    localparam int SII_NUM_PROG = 9;
    localparam int SII_NUM_FIXED = 7;
    localparam int SII_CODE_W = 4;
    localparam int SII_SEL_W = 5;
    // Serial bit map
    localparam logic [4:0] SII_BIT_TIMER = 5'h00;
    localparam logic [4:0] SII_BIT_MASK_LO = 5'h01;
    localparam logic [4:0] SII_BIT_FIXED_LO = 5'h10;
    localparam logic [4:0] SII_BIT_PROG_LO = 5'h17;
    // Interrupt input that the interval timer shares
    localparam int SII_TIMER_INT = 2;
    localparam logic [3:0] SII_CODE_NONE = 4'h0;
    // Interval timer period
    localparam int SII_CLK_PERIOD_NS = 10;
    localparam int SII_TIMER_PERIOD_NS = 1000;
    localparam int SII_TIMER_CYCLES = SII_TIMER_PERIOD_NS / SII_CLK_PERIOD_NS;
    localparam logic [7:0] SII_TIMER_LOAD = 8'(SII_TIMER_CYCLES - 1);
    // Avalon register byte offsets
    localparam logic [3:0] SII_REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] SII_REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] SII_REG_STATE = 4'h8;
    // Event bits of the status and mask registers
    localparam int SII_EV_W = 3;
    localparam int SII_EV_WRITE = 0;
    localparam int SII_EV_REQ = 1;
    localparam int SII_EV_TIMER = 2;
    // Field positions in the state register
    localparam int SII_ST_CODE_LO = 16;
    localparam int SII_ST_REQ = 20;
    localparam int SII_ST_TIMER = 24;
    localparam logic [14:0] SII_MASK_RESET = 15'h0000;
    localparam logic [8:0] SII_DIR_RESET = 9'h000;
endpackage

// ==== sii_prio_if.sv ====
// Interface between the register logic and the prioritizer
`timescale 1ns/1ps
interface sii_prio_if;
    import sii_pkg::*;
    logic [SII_NUM_INT-1:0] masked;
    logic clear;
    logic [SII_CODE_W-1:0] code;
    logic request;
    modport ctl (output masked, output clear, input code, input request);
    modport prio (input masked, input clear, output code, output request);
endinterface

// ==== sii_prio.sv ====
// Prioritizer and encoder for the fifteen masked interrupt inputs
`timescale 1ns/1ps
module sii_prio
    import sii_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    sii_prio_if.prio pif
);
    // Lowest input index wins; code is index plus one, zero means none
    function automatic logic [SII_CODE_W-1:0] encode(input logic [SII_NUM_INT-1:0] v);
        logic [SII_CODE_W-1:0] c;
        c = SII_CODE_NONE;
        for (int i = SII_NUM_INT - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = SII_CODE_W'(i + 1);
            end
        end
        return c;
    endfunction

    logic [SII_CODE_W-1:0] code_r;
    logic req_r;
    wire [SII_CODE_W-1:0] code_nxt = pif.clear ? SII_CODE_NONE : encode(pif.masked);
    wire req_nxt = !pif.clear && (|pif.masked);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= SII_CODE_NONE;
            req_r <= 1'b0;
        end else begin
            code_r <= code_nxt;
            req_r <= req_nxt;
        end
    end

    assign pif.code = code_r;
    assign pif.request = req_r;

    property p_top_wins;
        @(posedge clk) disable iff (!rst_n)
        (pif.masked[0] && !pif.clear) |=> (code_r == 4'h1);
    endproperty
    a_top_wins: assert property (p_top_wins) else $error("Input 0 did not win");
    property p_idle;
        @(posedge clk) disable iff (!rst_n)
        (pif.masked == '0) |=> (!req_r && code_r == SII_CODE_NONE);
    endproperty
    a_idle: assert property (p_idle) else $error("Request without pending input");
endmodule

// ==== sii_top.sv ====
// Serial I/O interrupt interface with Avalon-MM control registers
//
// How it works
// - six interrupt, nine programmable, seven output lines
// - fifteen inputs pass mask to prioritizer
// - highest priority active input encoded to four bits
// - request raised while enabled interrupt pends
// - sixteen I/O lines driven from serial logic
// - unused interrupt inputs readable as data
// - five select lines choose accessed bit
// - read line carries the selected bit
// - write line stored on strobe into bit
// - power-up reset clears mask, code, directions
// - read data passes only under chip enable
// - timer interrupts only while its clock runs, or from an expiry in the cycle that stops it
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sii_top
    import sii_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic IRQ_OUT,
    // Serial processor interface
    input wire logic [SII_SEL_W-1:0] BIT_SELECT_IN,
    input wire logic SERIAL_WRITE_LINE_IN,
    input wire logic SERIAL_WRITE_STROBE_IN,
    input wire logic CHIP_ENABLE_N_IN,
    input wire logic POWER_UP_RESET_N_IN,
    output logic SERIAL_READ_LINE_OUT,
    // Interrupt to processor
    output logic INTERRUPT_REQUEST_OUT,
    output logic [SII_CODE_W-1:0] INTERRUPT_CODE_OUT,
    // Line pins
    input wire logic [SII_NUM_INT_ONLY-1:0] INT_ONLY_IN,
    input wire logic [SII_NUM_PROG-1:0] PROG_IO_IN,
    output logic [SII_NUM_PROG-1:0] PROG_IO_OUT,
    output logic [SII_NUM_PROG-1:0] PROG_IO_OE_N_OUT,
    output logic [SII_NUM_FIXED-1:0] FIXED_IO_OUT
);
    localparam int PIN_W = SII_SEL_W + 4 + SII_NUM_INT_ONLY + SII_NUM_PROG;

    // Two-stage synchronisers for every pin input
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic strobe_prev_r;
    wire [PIN_W-1:0] pin_raw = {BIT_SELECT_IN, SERIAL_WRITE_LINE_IN, SERIAL_WRITE_STROBE_IN,
                                CHIP_ENABLE_N_IN, POWER_UP_RESET_N_IN, INT_ONLY_IN, PROG_IO_IN};

    wire [SII_NUM_PROG-1:0] prog_in_s = pin_s2_r[SII_NUM_PROG-1:0];
    wire [SII_NUM_INT_ONLY-1:0] int_only_s = pin_s2_r[SII_NUM_PROG +: SII_NUM_INT_ONLY];
    wire pur_n_s = pin_s2_r[SII_NUM_PROG + SII_NUM_INT_ONLY];
    wire ce_s = !pin_s2_r[SII_NUM_PROG + SII_NUM_INT_ONLY + 1];
    wire strobe_s = pin_s2_r[SII_NUM_PROG + SII_NUM_INT_ONLY + 2];
    wire wline_s = pin_s2_r[SII_NUM_PROG + SII_NUM_INT_ONLY + 3];
    wire [SII_SEL_W-1:0] sel_s = pin_s2_r[PIN_W-1 -: SII_SEL_W];
    // Strobe edge taken from the single internal clock; strobes wider than two cycles
    wire ser_wr = strobe_s && !strobe_prev_r && ce_s;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            strobe_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            strobe_prev_r <= strobe_s;
        end
    end

    // Command state
    logic [SII_NUM_INT-1:0] mask_r;
    // Kept inverted so the enable pins come straight from flops
    logic [SII_NUM_PROG-1:0] oe_n_r;
    logic [SII_NUM_PROG-1:0] prog_out_r;
    logic [SII_NUM_FIXED-1:0] fixed_r;
    logic timer_en_r;
    logic timer_pend_r;
    logic [7:0] timer_cnt_r;
    logic read_line_r;

    wire timer_hit = timer_en_r && (timer_cnt_r == 8'h00);
    wire [SII_NUM_INT-1:0] int_vec = {prog_in_s, int_only_s} |
                                    (SII_NUM_INT'(timer_pend_r) << SII_TIMER_INT);
    wire [SII_NUM_INT-1:0] masked = int_vec & mask_r;

    wire sel_timer = (sel_s == SII_BIT_TIMER);
    wire sel_mask = (sel_s >= SII_BIT_MASK_LO) && (sel_s < SII_BIT_FIXED_LO);
    wire sel_fixed = (sel_s >= SII_BIT_FIXED_LO) && (sel_s < SII_BIT_PROG_LO);
    wire [3:0] mask_idx = 4'(sel_s - SII_BIT_MASK_LO);
    wire [2:0] fixed_idx = 3'(sel_s - SII_BIT_FIXED_LO);
    wire [3:0] prog_idx = 4'(sel_s - SII_BIT_PROG_LO);
    // Interrupt inputs read as plain data whatever the mask
    wire sel_bit = sel_timer ? timer_en_r :
                   sel_mask ? int_vec[mask_idx] :
                   sel_fixed ? fixed_r[fixed_idx] :
                   prog_in_s[prog_idx];

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            mask_r <= SII_MASK_RESET;
            oe_n_r <= ~SII_DIR_RESET;
            prog_out_r <= '0;
            fixed_r <= '0;
            timer_en_r <= 1'b0;
        end else if (!pur_n_s) begin
            mask_r <= SII_MASK_RESET;
            oe_n_r <= ~SII_DIR_RESET;
            timer_en_r <= 1'b0;
        end else if (ser_wr) begin
            if (sel_timer) begin
                timer_en_r <= wline_s;
            end else if (sel_mask) begin
                mask_r[mask_idx] <= wline_s;
            end else if (sel_fixed) begin
                fixed_r[fixed_idx] <= wline_s;
            end else begin
                prog_out_r[prog_idx] <= wline_s;
                oe_n_r[prog_idx] <= 1'b0;
            end
        end
    end

    // Interval timer; pending is cleared by a write to the timer bit, except in a cycle where the timer expires
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            timer_cnt_r <= SII_TIMER_LOAD;
            timer_pend_r <= 1'b0;
        end else begin
            timer_cnt_r <= (!timer_en_r || timer_hit) ? SII_TIMER_LOAD : timer_cnt_r - 8'h01;
            if (timer_hit) begin
                timer_pend_r <= 1'b1;
            end else if ((ser_wr && sel_timer) || !pur_n_s) begin
                timer_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            read_line_r <= 1'b0;
        end else begin
            read_line_r <= ce_s && sel_bit;
        end
    end

    sii_prio_if pif ();
    assign pif.masked = masked;
    assign pif.clear = !pur_n_s;
    sii_prio u_prio (
        .clk(REF_CLK_IN),
        .rst_n(RSTN_IN),
        .pif(pif.prio)
    );

    // Avalon-MM slave: one wait state, then the access completes
    logic waitreq_r;
    logic [31:0] rdata_r;
    logic [SII_EV_W-1:0] ev_status_r;
    logic [SII_EV_W-1:0] ev_mask_r;
    logic irq_r;
    logic req_prev_r;

    wire av_req = AVS_READ_IN || AVS_WRITE_IN;
    wire av_wr = AVS_WRITE_IN && !waitreq_r && AVS_BYTEENABLE_IN[0];
    wire wr_status = av_wr && (AVS_ADDRESS_IN == SII_REG_IRQ_STATUS);
    wire wr_mask = av_wr && (AVS_ADDRESS_IN == SII_REG_IRQ_MASK);
    wire [31:0] state_word = (32'(timer_en_r) << SII_ST_TIMER) |
                             (32'(pif.request) << SII_ST_REQ) |
                             (32'(pif.code) << SII_ST_CODE_LO) | 32'(mask_r);
    logic [31:0] rd_mux;
    always_comb begin
        if (AVS_ADDRESS_IN == SII_REG_IRQ_STATUS) begin
            rd_mux = 32'(ev_status_r);
        end else if (AVS_ADDRESS_IN == SII_REG_IRQ_MASK) begin
            rd_mux = 32'(ev_mask_r);
        end else if (AVS_ADDRESS_IN == SII_REG_STATE) begin
            rd_mux = state_word;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    wire [SII_EV_W-1:0] ev_now;
    assign ev_now[SII_EV_WRITE] = ser_wr;
    assign ev_now[SII_EV_REQ] = pif.request && !req_prev_r;
    assign ev_now[SII_EV_TIMER] = timer_hit;
    // A new event outranks a clear in the same cycle
    wire [SII_EV_W-1:0] clr_bits = wr_status ? AVS_WRITEDATA_IN[SII_EV_W-1:0] : '0;
    wire [SII_EV_W-1:0] ev_status_nxt = (ev_status_r & ~clr_bits) | ev_now;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            waitreq_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            ev_status_r <= '0;
            ev_mask_r <= '0;
            irq_r <= 1'b0;
            req_prev_r <= 1'b0;
        end else begin
            waitreq_r <= !(av_req && waitreq_r);
            if (AVS_READ_IN && waitreq_r) begin
                rdata_r <= rd_mux;
            end
            if (wr_mask) begin
                ev_mask_r <= AVS_WRITEDATA_IN[SII_EV_W-1:0];
            end
            ev_status_r <= ev_status_nxt;
            irq_r <= |(ev_status_nxt & (wr_mask ? AVS_WRITEDATA_IN[SII_EV_W-1:0] : ev_mask_r));
            req_prev_r <= pif.request;
        end
    end

    assign AVS_READDATA_OUT = rdata_r;
    assign AVS_WAITREQUEST_OUT = waitreq_r;
    assign IRQ_OUT = irq_r;
    assign SERIAL_READ_LINE_OUT = read_line_r;
    assign INTERRUPT_REQUEST_OUT = pif.request;
    assign INTERRUPT_CODE_OUT = pif.code;
    assign PROG_IO_OUT = prog_out_r;
    assign PROG_IO_OE_N_OUT = oe_n_r;
    assign FIXED_IO_OUT = fixed_r;

    // Checks
    property p_ce_gate;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !ce_s |=> !SERIAL_READ_LINE_OUT;
    endproperty
    a_ce_gate: assert property (p_ce_gate) else $error("Read line active without enable");
    property p_read_bit;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        ce_s |=> (SERIAL_READ_LINE_OUT == $past(sel_bit));
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("Read line not the selected bit");
    property p_mask_write;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (ser_wr && sel_mask && pur_n_s) |=> (mask_r[$past(mask_idx)] == $past(wline_s));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("Mask bit not written");
    property p_pur_clear;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !pur_n_s |=> (mask_r == '0 && PROG_IO_OE_N_OUT == '1) ##1 (INTERRUPT_CODE_OUT == 4'h0);
    endproperty
    a_pur_clear: assert property (p_pur_clear) else $error("Power-up reset incomplete");
    property p_masked_off;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (mask_r == '0) |=> !INTERRUPT_REQUEST_OUT;
    endproperty
    a_masked_off: assert property (p_masked_off) else $error("Request with all inputs masked");
    property p_timer_off;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (!timer_en_r && !timer_pend_r) |=> !timer_pend_r;
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("Timer fired while disabled");
    property p_req_follows;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (masked != '0 && pur_n_s) |=> INTERRUPT_REQUEST_OUT;
    endproperty
    a_req_follows: assert property (p_req_follows) else $error("Pending input gave no request");
    property p_prog_out;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (ser_wr && !sel_timer && !sel_mask && !sel_fixed && pur_n_s)
            |=> (PROG_IO_OE_N_OUT[$past(prog_idx)] == 1'b0);
    endproperty
    a_prog_out: assert property (p_prog_out) else $error("Written line not driven");
    property p_wait_one;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        (av_req && waitreq_r) |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Bus answer not after one wait");
    property p_pur_code;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !pur_n_s |=> (INTERRUPT_CODE_OUT == SII_CODE_NONE && !INTERRUPT_REQUEST_OUT);
    endproperty
    a_pur_code: assert property (p_pur_code) else $error("Code kept through power-up reset");
    // The line lags status and mask by nothing once both are registered
    property p_irq_level;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        IRQ_OUT == (|(ev_status_r & ev_mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt line not status and mask");
    property p_wr_gated;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        !ce_s |=> ($stable(fixed_r) && $stable(prog_out_r));
    endproperty
    a_wr_gated: assert property (p_wr_gated) else $error("Serial write taken while disabled");
    // Expiry must win over a clear in the same cycle
    property p_timer_pend;
        @(posedge REF_CLK_IN) disable iff (!RSTN_IN)
        timer_hit |=> timer_pend_r;
    endproperty
    a_timer_pend: assert property (p_timer_pend) else $error("Timer expiry lost");
    c_serial_write: cover property (@(posedge REF_CLK_IN) ser_wr && sel_mask);
    c_request: cover property (@(posedge REF_CLK_IN) INTERRUPT_REQUEST_OUT);
    c_timer: cover property (@(posedge REF_CLK_IN) timer_hit);
    c_irq: cover property (@(posedge REF_CLK_IN) IRQ_OUT);
endmodule

// ==== sii_cpu_model.sv ====
// Behavioural processor that drives the serial bit interface
`timescale 1ns/1ps
module sii_cpu_model
    import sii_pkg::*;
(
    input wire logic clk,
    input wire logic read_line,
    output logic [SII_SEL_W-1:0] sel,
    output logic wr_line,
    output logic strobe,
    output logic ce_n,
    output logic pur_n
);
    initial begin
        sel = '0;
        wr_line = 1'b0;
        strobe = 1'b0;
        ce_n = 1'b0;
        pur_n = 1'b1;
    end
    // Each strobe phase lasts 3 cycles, one more than the input sync needs
    task automatic wr_bit(input logic [SII_SEL_W-1:0] b, input logic v);
        @(posedge clk);
        sel <= b;
        wr_line <= v;
        strobe <= 1'b1;
        repeat (3) @(posedge clk);
        strobe <= 1'b0;
        repeat (3) @(posedge clk);
        // Data is meaningless outside a strobe, so show the inverse
        wr_line <= ~v;
    endtask
    task automatic rd_bit(input logic [SII_SEL_W-1:0] b, output logic v);
        @(posedge clk);
        sel <= b;
        repeat (5) @(posedge clk);
        v = read_line;
    endtask
    // Enable and power-up reset come from glue logic as plain levels
    task automatic set_ce(input logic en);
        @(posedge clk);
        ce_n <= ~en;
    endtask
    task automatic pulse_reset;
        @(posedge clk);
        pur_n <= 1'b0;
        repeat (4) @(posedge clk);
        pur_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ==== serial_io_interrupt_interface_test.sv ====
// Self-checking testbench of the serial I/O interrupt interface
`timescale 1ns/1ps
`define SII_CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t %s", $time, m); end end
module serial_io_interrupt_interface_test;
    import sii_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_r;
    logic irq;
    logic rline;
    logic req;
    logic [3:0] code;
    logic [4:0] sel;
    logic wl;
    logic stb;
    logic ce_n;
    logic pur_n;
    logic [5:0] int_only = '0;
    logic [8:0] prog_in = '0;
    logic [8:0] prog_out;
    logic [8:0] oe_n;
    logic [6:0] fixed;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] d;
    logic v;
    always #5 clk = ~clk;
    sii_top DUT (.REF_CLK_IN(clk), .RSTN_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_r), .IRQ_OUT(irq),
        .BIT_SELECT_IN(sel), .SERIAL_WRITE_LINE_IN(wl), .SERIAL_WRITE_STROBE_IN(stb),
        .CHIP_ENABLE_N_IN(ce_n), .POWER_UP_RESET_N_IN(pur_n), .SERIAL_READ_LINE_OUT(rline),
        .INTERRUPT_REQUEST_OUT(req), .INTERRUPT_CODE_OUT(code), .INT_ONLY_IN(int_only),
        .PROG_IO_IN(prog_in), .PROG_IO_OUT(prog_out), .PROG_IO_OE_N_OUT(oe_n),
        .FIXED_IO_OUT(fixed));
    sii_cpu_model cpu (.clk(clk), .read_line(rline), .sel(sel), .wr_line(wl), .strobe(stb),
        .ce_n(ce_n), .pur_n(pur_n));
    task automatic end_sim;
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] dt);
        int n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= dt;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 20);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        `SII_CHK(wait_r, 1'b0, "no bus answer")
    endtask
    task automatic set_in(input logic [14:0] x);
        @(posedge clk);
        int_only <= x[5:0];
        prog_in <= x[14:6];
        repeat (5) @(posedge clk);
    endtask
    task automatic t_reset;
        `SII_CHK(code, SII_CODE_NONE, "code after reset")
        `SII_CHK(req, 1'b0, "request after reset")
        `SII_CHK(oe_n, 9'h1FF, "lines not input after reset")
        `SII_CHK(irq, 1'b0, "irq after reset")
    endtask
    task automatic t_prio;
        for (int i = 0; i < 15; i++) cpu.wr_bit(5'(i + 1), 1'b1);
        av(1'b0, SII_REG_STATE, '0);
        `SII_CHK(d[14:0], 15'h7FFF, "mask field")
        // Higher inputs stay active so only the ranking picks the code
        for (int i = 0; i < 15; i++) begin
            set_in(15'h7FFF << i);
            `SII_CHK(code, 4'(i + 1), "priority code")
            `SII_CHK(req, 1'b1, "request pending")
        end
        set_in(15'h0000);
        `SII_CHK({req, code}, 5'h00, "idle request and code")
        cpu.wr_bit(5'h05, 1'b0);
        set_in(15'h0210);
        `SII_CHK(code, 4'hA, "masked input skipped")
        set_in(15'h0010);
        `SII_CHK(req, 1'b0, "masked input requested")
    endtask
    task automatic t_read;
        set_in(15'h5A3C);
        for (int i = 0; i < 15; i++) begin
            cpu.rd_bit(5'(i + 1), v);
            `SII_CHK(v, 1'((15'h5A3C >> i) & 15'h1), "input level read")
        end
        cpu.rd_bit(5'h1A, v);
        `SII_CHK(v, 1'b1, "programmable line high read")
        cpu.rd_bit(5'h17, v);
        `SII_CHK(v, 1'b0, "programmable line low read")
        cpu.set_ce(1'b0);
        cpu.rd_bit(5'h03, v);
        `SII_CHK(v, 1'b0, "read while disabled")
        cpu.wr_bit(5'h10, 1'b1);
        `SII_CHK(fixed, 7'h00, "write while disabled")
        cpu.set_ce(1'b1);
    endtask
    task automatic t_out;
        for (int i = 0; i < 7; i++) cpu.wr_bit(5'(16 + i), 1'((7'h55 >> i) & 7'h1));
        `SII_CHK(fixed, 7'h55, "fixed lines")
        cpu.rd_bit(5'h12, v);
        `SII_CHK(v, 1'b1, "fixed readback")
        for (int i = 0; i < 9; i++) cpu.wr_bit(5'(23 + i), 1'((9'h16B >> i) & 9'h1));
        `SII_CHK(prog_out, 9'h16B, "programmable values")
        `SII_CHK(oe_n, 9'h000, "programmable not driving")
        set_in(15'h0001);
        `SII_CHK(code, 4'h1, "code before power-up reset")
        cpu.pulse_reset;
        `SII_CHK({req, code}, 5'h00, "power-up reset code")
        `SII_CHK(oe_n, 9'h1FF, "power-up reset directions")
        av(1'b0, SII_REG_STATE, '0);
        `SII_CHK(d[14:0], SII_MASK_RESET, "power-up reset mask")
    endtask
    task automatic t_timer;
        set_in(15'h0000);
        cpu.wr_bit(5'(SII_TIMER_INT + 1), 1'b1);
        cpu.wr_bit(SII_BIT_TIMER, 1'b1);
        repeat (150) @(posedge clk);
        `SII_CHK(code, 4'(SII_TIMER_INT + 1), "timer code")
        av(1'b0, SII_REG_STATE, '0);
        `SII_CHK(d[SII_ST_TIMER], 1'b1, "timer enable state")
        cpu.wr_bit(SII_BIT_TIMER, 1'b0);
        repeat (250) @(posedge clk);
        `SII_CHK({req, code}, 5'h00, "stopped timer interrupt")
    endtask
    task automatic t_irq;
        av(1'b1, SII_REG_IRQ_MASK, 32'h7);
        av(1'b1, SII_REG_IRQ_STATUS, 32'h7);
        av(1'b0, SII_REG_IRQ_STATUS, '0);
        `SII_CHK(d, 32'h0, "status cleared")
        cpu.wr_bit(5'h10, 1'b0);
        `SII_CHK(irq, 1'b1, "write event irq")
        cpu.wr_bit(5'h01, 1'b1);
        set_in(15'h0001);
        av(1'b0, SII_REG_IRQ_STATUS, '0);
        `SII_CHK(d, 32'h3, "write and request events")
        av(1'b1, SII_REG_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk);
        `SII_CHK(irq, 1'b0, "masked irq")
        be <= 4'h0;
        av(1'b1, SII_REG_IRQ_STATUS, 32'h3);
        be <= 4'hF;
        av(1'b0, SII_REG_IRQ_STATUS, '0);
        `SII_CHK(d, 32'h3, "write without lane 0")
        av(1'b1, SII_REG_IRQ_STATUS, 32'h3);
        av(1'b1, 4'hC, 32'hFFFFFFFF);
        av(1'b0, 4'hC, '0);
        `SII_CHK(d, 32'h0, "unmapped read")
        av(1'b0, SII_REG_IRQ_STATUS, '0);
        `SII_CHK(d, 32'h0, "status after clear")
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_prio;
        t_read;
        t_out;
        t_timer;
        t_irq;
        end_sim;
    end
endmodule
